/* hdl/qep_pkg.sv */
// Overview of operation
// RULE1 - Bits 9, 8 stop dequeue instances 2, 1
// RULE2 - Bit 7 stops transmit statistics update process
// RULE3 - Software writes zero to reserved bit 6
// RULE4 - Bit 5 stops multicast replication instance 2
// RULE5 - Bit 4 stops multicast instances 1 and 3
// RULE6 - Bit 3 stops enqueue instance 4, port 3
// RULE7 - Bit 2 stops enqueue instance 3, port 2
// RULE8 - Bits 1, 0 stop enqueue instances 2, 1
// RULE9 - Health flags read-only, word 2A, reset zero
// RULE10 - Bit 31 flags even parity on last read
// RULE11 - Bit 30 set unless start every 118 clocks
// RULE12 - Bits 29 to 27 always read zero
// RULE13 - Bit 26 flags VCI bit above configured width
// RULE14 - Bit 25 flags illegal transmit group counters
// RULE15 - Bit 24 flags illegal receive group counters
// RULE16 - Bits 23..21 flag negative transmit group depths
// RULE17 - Bit 20 flags negative total transmit depth
// RULE18 - Software resets device after fatal flags
// RULE19 - Bit 10 stops dequeue instance 3
// RULE20 - Flags follow condition; reads clear nothing
`default_nettype none
package qep_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  HEALTH_IDX   = 8'h2A;
  localparam logic [7:0]  CONTROL_IDX  = 8'h2B;
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0000;
  localparam logic [31:0] HEALTH_RST   = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_07BF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ==========================================================
  // Control field positions
  localparam int ENQ1_BIT  = 0;
  localparam int ENQ2_BIT  = 1;
  localparam int ENQ3_BIT  = 2;
  localparam int ENQ4_BIT  = 3;
  localparam int MC13_BIT  = 4;
  localparam int MC2_BIT   = 5;
  localparam int STAT_BIT  = 7;
  localparam int DEQ1_BIT  = 8;
  localparam int DEQ2_BIT  = 9;
  localparam int DEQ3_BIT  = 10;
  // ==========================================================
  // Health field positions
  localparam int PAR_BIT   = 31;
  localparam int SYNC_BIT  = 30;
  localparam int VCI_BIT   = 26;
  localparam int TXG_BIT   = 25;
  localparam int RXG_BIT   = 24;
  localparam int TX12_BIT  = 23;
  localparam int TX8_BIT   = 22;
  localparam int TX4_BIT   = 21;
  localparam int TXD_BIT   = 20;
  // ==========================================================
  // Fabric timing
  localparam int CELL_PERIOD = 118;
endpackage : qep_pkg
`default_nettype wire

/* hdl/qep_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qep_top #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cell_ram_rd_valid,
  input  wire logic        cell_ram_rd_parity,
  input  wire logic        fabric_clock,
  input  wire logic        rx_cell_start,
  input  wire logic        cell_rx_valid,
  input  wire logic        cell_per_vc,
  input  wire logic [15:0] cell_vci,
  input  wire logic [3:0]  vci_width_setting,
  input  wire logic [CNT_W-1:0] tx_cnt_low12,
  input  wire logic [CNT_W-1:0] tx_cnt_low4,
  input  wire logic [CNT_W-1:0] rx_cnt_low48,
  input  wire logic [CNT_W-1:0] rx_cnt_low16,
  input  wire logic        tx_grp12_depth_negative,
  input  wire logic        tx_grp8_depth_negative,
  input  wire logic        tx_grp4_depth_negative,
  input  wire logic        tx_total_depth_negative,
  output var  logic        dequeue_inst1_off,
  output var  logic        dequeue_inst2_off,
  output var  logic        dequeue_inst3_off,
  output var  logic        stats_update_off,
  output var  logic        mcast_repl_inst2_off,
  output var  logic        mcast_repl_inst13_off,
  output var  logic        enqueue_inst1_off,
  output var  logic        enqueue_inst2_off,
  output var  logic        enqueue_inst3_off,
  output var  logic        enqueue_inst4_off
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]  fc_sync;
    logic [1:0]  cs_sync;
    logic        fc_last;
    logic        cs_last;
    logic [7:0]  period;
    logic        started;
    logic [31:0] control;
    logic [31:0] health;
    logic        aw_held;
    logic [7:0]  aw_idx;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } qep_state_t;

  qep_state_t st;
  qep_state_t next_st;

  // Word index from a byte address; unaligned high bits must be zero
  function automatic logic [8:0] qep_decode(input logic [31:0] a);
    qep_decode = {(a[31:10] == 22'h0 && a[1:0] == 2'h0), a[9:2]};
  endfunction : qep_decode

  // Byte-lane merge of write data
  function automatic logic [31:0] qep_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    qep_merge = r;
  endfunction : qep_merge

  logic fc_rise;
  logic cs_rise;
  logic vci_excess;
  logic [15:0] vci_limit;
  logic [8:0]  wdec;
  logic [8:0]  rdec;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.fc_sync = {st.fc_sync[0], fabric_clock};
    next_st.cs_sync = {st.cs_sync[0], rx_cell_start};
    next_st.fc_last = st.fc_sync[1];
    next_st.cs_last = st.cs_sync[1];
    fc_rise = st.fc_sync[1] & ~st.fc_last;
    cs_rise = st.cs_sync[1] & ~st.cs_last;
    vci_limit  = 16'hFFFF >> (5'h10 - {1'b0, vci_width_setting});
    vci_excess = |(cell_vci & ~vci_limit);
    wdec = qep_decode(s_axi_awaddr);
    rdec = qep_decode(s_axi_araddr);

    // Fabric clock edges counted between cell starts
    if (fc_rise && !cs_rise) begin
      if (st.period != 8'hFF) begin
        next_st.period = st.period + 8'h01;
      end
      // A start missing past the full interval is a loss of sync
      if (st.started && st.period >= 8'(qep_pkg::CELL_PERIOD)) begin
        next_st.health[qep_pkg::SYNC_BIT] = 1'b1; // [RULE11]
      end
    end
    // A start judges the finished interval, then opens a new one
    if (cs_rise) begin
      next_st.period  = fc_rise ? 8'h01 : 8'h00;
      next_st.started = 1'b1;
      next_st.health[qep_pkg::SYNC_BIT] = st.started &&
        (st.period != 8'(qep_pkg::CELL_PERIOD)); // [RULE11]
    end

    // Parity of last cell RAM read; even means error
    if (cell_ram_rd_valid) begin
      next_st.health[qep_pkg::PAR_BIT] = ~cell_ram_rd_parity; // [RULE10]
    end
    // Unused VCI bit on the latest received cell, flagged only when it is per-VC
    if (cell_rx_valid) begin
      next_st.health[qep_pkg::VCI_BIT] = cell_per_vc & vci_excess; // [RULE13]
    end
    // Live condition flags follow their inputs [RULE20]
    next_st.health[qep_pkg::TXG_BIT] = (tx_cnt_low12 == '0) &&
                                       (tx_cnt_low4 != '0); // [RULE14]
    next_st.health[qep_pkg::RXG_BIT] = (rx_cnt_low48 == '0) &&
                                       (rx_cnt_low16 != '0); // [RULE15]
    next_st.health[qep_pkg::TX12_BIT] = tx_grp12_depth_negative; // [RULE16]
    next_st.health[qep_pkg::TX8_BIT]  = tx_grp8_depth_negative;  // [RULE16]
    next_st.health[qep_pkg::TX4_BIT]  = tx_grp4_depth_negative;  // [RULE16]
    next_st.health[qep_pkg::TXD_BIT]  = tx_total_depth_negative; // [RULE17]
    next_st.health[29:27] = 3'h0; // [RULE12]
    next_st.health[19:0]  = 20'h0;

    // Write address and data captured in either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = wdec[8] ? wdec[7:0] : 8'hFF;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    // Write commit; health is read-only so writes there fail
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      if (st.aw_idx == qep_pkg::CONTROL_IDX) begin
        next_st.control = qep_merge(st.control, st.w_data, st.w_strb)
                          & qep_pkg::CONTROL_MASK; // [RULE3]
        next_st.bresp   = qep_pkg::RESP_OKAY;
      end else begin
        next_st.bresp   = qep_pkg::RESP_SLVERR; // [RULE9]
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read path; no read side effects [RULE20]
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = qep_pkg::RESP_OKAY;
      if (rdec[8] && rdec[7:0] == qep_pkg::HEALTH_IDX) begin
        next_st.rdata = st.health; // [RULE9]
      end else if (rdec[8] && rdec[7:0] == qep_pkg::CONTROL_IDX) begin
        next_st.rdata = st.control;
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = qep_pkg::RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Readies kept in flops so no output leaves through a gate
    next_st.aw_rdy = ~next_st.aw_held;
    next_st.w_rdy  = ~next_st.w_held;
    next_st.ar_rdy = ~next_st.rvalid;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.control <= qep_pkg::CONTROL_RST;
      st.health  <= qep_pkg::HEALTH_RST; // [RULE9]
      st.aw_rdy  <= 1'b1;
      st.w_rdy   <= 1'b1;
      st.ar_rdy  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready  = st.w_rdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata  = st.rdata;
  assign s_axi_rresp  = st.rresp;
  // Process stop controls
  assign dequeue_inst1_off     = st.control[qep_pkg::DEQ1_BIT]; // [RULE1]
  assign dequeue_inst2_off     = st.control[qep_pkg::DEQ2_BIT]; // [RULE1]
  assign dequeue_inst3_off     = st.control[qep_pkg::DEQ3_BIT]; // [RULE19]
  assign stats_update_off      = st.control[qep_pkg::STAT_BIT]; // [RULE2]
  assign mcast_repl_inst2_off  = st.control[qep_pkg::MC2_BIT];  // [RULE4]
  assign mcast_repl_inst13_off = st.control[qep_pkg::MC13_BIT]; // [RULE5]
  assign enqueue_inst4_off     = st.control[qep_pkg::ENQ4_BIT]; // [RULE6]
  assign enqueue_inst3_off     = st.control[qep_pkg::ENQ3_BIT]; // [RULE7]
  assign enqueue_inst2_off     = st.control[qep_pkg::ENQ2_BIT]; // [RULE8]
  assign enqueue_inst1_off     = st.control[qep_pkg::ENQ1_BIT]; // [RULE8]

  // ==========================================================
  // Checks
  chk_ctl_drives_off: assert property ( // [RULE6]
    @(posedge clk) disable iff (!rst_n)
    enqueue_inst4_off == st.control[3] && dequeue_inst1_off == st.control[8])
    else $error("control bit not on stop output");

  chk_health_unused: assert property ( // [RULE12]
    @(posedge clk) disable iff (!rst_n)
    st.health[29:27] == 3'h0)
    else $error("unused health bits not zero");

  chk_txneg_follows: assert property ( // [RULE17]
    @(posedge clk) disable iff (!rst_n)
    ##1 st.health[20] == $past(tx_total_depth_negative))
    else $error("total depth flag does not follow");

  chk_grp_follows: assert property ( // [RULE16]
    @(posedge clk) disable iff (!rst_n)
    ##1 st.health[23] == $past(tx_grp12_depth_negative))
    else $error("group12 flag does not follow");

  chk_txg_illegal: assert property ( // [RULE14]
    @(posedge clk) disable iff (!rst_n)
    (tx_cnt_low12 == '0 && tx_cnt_low4 != '0) |=> st.health[25])
    else $error("tx group illegal not flagged");

  chk_rxg_illegal: assert property ( // [RULE15]
    @(posedge clk) disable iff (!rst_n)
    (rx_cnt_low48 != '0) |=> !st.health[24])
    else $error("rx group flagged while legal");

  chk_parity_even: assert property ( // [RULE10]
    @(posedge clk) disable iff (!rst_n)
    (cell_ram_rd_valid && !cell_ram_rd_parity) |=> st.health[31])
    else $error("even parity not flagged");

  chk_health_ro: assert property ( // [RULE9]
    @(posedge clk) disable iff (!rst_n)
    (st.aw_held && st.w_held && !st.bvalid &&
     st.aw_idx == qep_pkg::HEALTH_IDX) |=> s_axi_bresp == 2'h2)
    else $error("health write accepted");

  chk_read_stable: assert property ( // [RULE20]
    @(posedge clk) disable iff (!rst_n)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  chk_ctl_reserved: assert property ( // [RULE3]
    @(posedge clk) disable iff (!rst_n)
    st.control[6] == 1'b0 && st.control[31:11] == 21'h0)
    else $error("reserved control bit set");

  chk_ready_mirror: assert property ( // [RULE9]
    @(posedge clk) disable iff (!rst_n)
    s_axi_awready == !st.aw_held && s_axi_wready == !st.w_held &&
    s_axi_arready == !st.rvalid)
    else $error("bus ready does not match hold state");

  chk_deq12_off: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rst_n)
    dequeue_inst2_off == st.control[9] && dequeue_inst1_off == st.control[8])
    else $error("dequeue stop output wrong");

  chk_sync_overrun: assert property ( // [RULE11]
    @(posedge clk) disable iff (!rst_n)
    (fc_rise && !cs_rise && st.started &&
     st.period >= 8'(qep_pkg::CELL_PERIOD)) |=> st.health[30])
    else $error("late cell start not flagged");

  chk_sync_good: assert property ( // [RULE11]
    @(posedge clk) disable iff (!rst_n)
    (cs_rise && st.started && st.period == 8'(qep_pkg::CELL_PERIOD))
    |=> !st.health[30])
    else $error("correct cell interval still flagged");

  chk_parity_odd: assert property ( // [RULE10]
    @(posedge clk) disable iff (!rst_n)
    (cell_ram_rd_valid && cell_ram_rd_parity) |=> !st.health[31])
    else $error("odd parity flagged");

  chk_rxg_flag: assert property ( // [RULE15]
    @(posedge clk) disable iff (!rst_n)
    (rx_cnt_low48 == '0 && rx_cnt_low16 != '0) |=> st.health[24])
    else $error("rx group illegal not flagged");

  chk_stat_off: assert property ( // [RULE2]
    @(posedge clk) disable iff (!rst_n)
    stats_update_off == st.control[7] &&
    mcast_repl_inst2_off == st.control[5])
    else $error("statistics or multicast stop wrong");

  chk_deq3_off: assert property ( // [RULE19]
    @(posedge clk) disable iff (!rst_n)
    dequeue_inst3_off == st.control[10])
    else $error("third dequeue stop wrong");

  chk_enq_low: assert property ( // [RULE8]
    @(posedge clk) disable iff (!rst_n)
    enqueue_inst1_off == st.control[0] && enqueue_inst2_off == st.control[1])
    else $error("low enqueue stop wrong");
endmodule : qep_top
`default_nettype wire

/* testbench/test_queue_engine_process_ctl_status.sv */
`timescale 1ns/1ps
`default_nettype none
module test_queue_engine_process_ctl_status;
  // ==========================================================
  // Stimulus and observation signals
  localparam logic [31:0] A_CTL = {22'h0, qep_pkg::CONTROL_IDX, 2'h0};
  localparam logic [31:0] A_HLT = {22'h0, qep_pkg::HEALTH_IDX, 2'h0};
  logic        clk, rst_n, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic        pv, par, fclk, cst, cv, pvc;
  logic [31:0] awaddr, wdata, araddr, rdata, d, e;
  logic [3:0]  wstrb, vw, neg;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] vci, t12, t4, r48, r16;
  wire logic [9:0] offs;
  int          n_mismatch, n_compared;
  logic [31:0] rows [13][2] = '{'{32'h1, 32'h1}, '{32'h2, 32'h2},
    '{32'h4, 32'h4}, '{32'h8, 32'h8}, '{32'h10, 32'h10},
    '{32'h20, 32'h20}, '{32'h2AA, 32'h2AA}, '{32'h80, 32'h80},
    '{32'h100, 32'h100}, '{32'h200, 32'h200}, '{32'h400, 32'h400},
    '{32'hFFFFFFBF, 32'h7BF}, '{32'h0, 32'h0}};

  qep_top qep_top_inst (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .cell_ram_rd_valid(pv), .cell_ram_rd_parity(par), .fabric_clock(fclk),
    .rx_cell_start(cst), .cell_rx_valid(cv), .cell_per_vc(pvc),
    .cell_vci(vci), .vci_width_setting(vw), .tx_cnt_low12(t12),
    .tx_cnt_low4(t4), .rx_cnt_low48(r48), .rx_cnt_low16(r16),
    .tx_grp12_depth_negative(neg[3]), .tx_grp8_depth_negative(neg[2]),
    .tx_grp4_depth_negative(neg[1]), .tx_total_depth_negative(neg[0]),
    .dequeue_inst1_off(offs[7]), .dequeue_inst2_off(offs[8]),
    .dequeue_inst3_off(offs[9]), .stats_update_off(offs[6]),
    .mcast_repl_inst2_off(offs[5]), .mcast_repl_inst13_off(offs[4]),
    .enqueue_inst1_off(offs[0]), .enqueue_inst2_off(offs[1]),
    .enqueue_inst3_off(offs[2]), .enqueue_inst4_off(offs[3]));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] ex, g);
    n_compared++;
    if (g !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  // Bus write, held until each channel is taken
  task automatic wrt(input logic [31:0] a, dd, input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a;
    wdata  <= dd;
    wstrb  <= s;
    awv    <= 1'b1;
    wv     <= 1'b1;
    br     <= 1'b1;
    do begin
      @(negedge clk);
      ah = awv & awr;
      wh = wv & wrdy;
      bh = bv;
      r  = bresp;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end while (!bh);
    br <= 1'b0;
  endtask : wrt

  // Bus read, data kept in d and response in r; rready after lag cycles
  task automatic rdt(input logic [31:0] a, input int lag = 0);
    logic ah, rh;
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rr     <= (lag == 0);
    do begin
      @(negedge clk);
      ah = arv & arr;
      rh = rv & rr;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ah) arv <= 1'b0;
      if (lag > 0) lag--;
      if (lag == 0 && !rh) rr <= 1'b1;
    end while (!rh);
    rr <= 1'b0;
  endtask : rdt

  task automatic hc(input logic [31:0] ex);
    rdt(A_HLT);
    chk("health", ex, d);
  endtask : hc

  // Fabric clock periods of four system clocks, then a start pulse
  task automatic fab(input int n);
    repeat (n) begin
      fclk <= 1'b1;
      repeat (2) @(posedge clk);
      fclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    cst <= 1'b1;
    repeat (2) @(posedge clk);
    cst <= 1'b0;
  endtask : fab

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {awv, wv, br, arv, rr, pv, par, fclk, cst, cv, pvc} = '0;
    {awaddr, wdata, araddr, wstrb, vw, neg, vci} = '0;
    {t12, t4, r48, r16} = '0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    hc(32'h0);
    rdt(A_CTL);
    chk("control reset", 32'h0, d);
    foreach (rows[i]) begin
      wrt(A_CTL, rows[i][0], 4'hF);
      chk("bresp", {30'h0, qep_pkg::RESP_OKAY}, {30'h0, r});
      rdt(A_CTL);
      chk("control", rows[i][1], d);
      e = rows[i][1];
      chk("offs", {22'h0, e[10:7], e[5:0]}, {22'h0, offs});
    end
    $display("test control rows done");
    wrt(A_CTL, 32'hFFFFFFBF, 4'h2);
    rdt(A_CTL);
    chk("control lane", 32'h700, d);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("offs reset", 32'h0, {22'h0, offs});
    rst_n <= 1'b1;
    rdt(A_CTL);
    chk("control after reset", 32'h0, d);
    wrt(A_HLT, 32'hFFFFFFFF, 4'hF);
    chk("health wr", {30'h0, qep_pkg::RESP_SLVERR}, {30'h0, r});
    hc(32'h0);
    rdt(32'h400);
    chk("unmapped", {30'h0, qep_pkg::RESP_SLVERR}, {30'h0, r});
    $display("test access done");
    pv <= 1'b1;
    @(posedge clk);
    pv <= 1'b0;
    hc(32'h80000000);
    hc(32'h80000000);
    {pv, par} <= 2'h3;
    @(posedge clk);
    pv <= 1'b0;
    {vw, pvc, vci, cv} <= {4'h4, 1'b1, 16'h0010, 1'b1};
    @(posedge clk);
    cv <= 1'b0;
    hc(32'h04000000);
    {vci, cv} <= {16'h000F, 1'b1};
    @(posedge clk);
    cv <= 1'b0;
    {t4, r16} <= {16'h1, 16'h2};
    hc(32'h03000000);
    {t12, r48, neg} <= {16'h3, 16'h5, 4'hA};
    hc(32'h00A00000);
    neg <= 4'h5;
    hc(32'h00500000);
    neg <= 4'h0;
    $display("test health flags done");
    fab(0);
    repeat (2) fab(118);
    hc(32'h0);
    fab(117);
    hc(32'h40000000);
    fab(118);
    hc(32'h0);
    fab(119);
    hc(32'h40000000);
    $display("test fabric sync done");
    neg <= 4'hF;
    hc(32'h40F00000);
    neg <= 4'h0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    hc(32'h0);
    rdt(A_CTL, 3);
    chk("slow read", 32'h0, d);
    $display("test recovery reset done");
    print_verdict();
  end
endmodule : test_queue_engine_process_ctl_status
`default_nettype wire
